/* File: src/lcsr_map.svh */
/*
  Register offsets, field positions, reset values and timing counts for the
  controller status/control bank.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef LCSR_MAP_SVH
`define LCSR_MAP_SVH

// Byte offsets on the register bus
`define LCSR_OFS_CSC 12'h000
`define LCSR_OFS_MASK 12'h004
`define LCSR_OFS_XMASK 12'h008
`define LCSR_OFS_CFG 12'h00c
`define LCSR_OFS_EVT 12'h010

// Control/status word field positions
`define LCSR_B_ERR 15
`define LCSR_B_OVL 14
`define LCSR_B_COL 13
`define LCSR_B_MISS 12
`define LCSR_B_MEM 11
`define LCSR_B_RXD 10
`define LCSR_B_TXD 9
`define LCSR_B_SET 8
`define LCSR_B_INT 7
`define LCSR_B_IEN 6
`define LCSR_B_RECEIVER_RUNNING 5
`define LCSR_B_TRANSMITTER_RUNNING 4
`define LCSR_B_POLL 3
`define LCSR_B_STOP 2
`define LCSR_B_BEGIN 1
`define LCSR_B_INIT 0

// Extended mask / flag positions
`define LCSR_X_LBE 1
`define LCSR_X_TXB 0

// Config word positions
`define LCSR_C_DRX 0
`define LCSR_C_DTX 1

// Reset values
`define LCSR_RST_CSC 16'h0004
`define LCSR_RST_MASK 16'h0000

// Timing: memory ready timeout in clock counts
`define LCSR_MEM_TIMEOUT 512
// Init block fetch length in words (word fetch model)
`define LCSR_INIT_WORDS 12
// Periodic transmit poll reload count; polls repeat every 1601 clock cycles
`define LCSR_POLL_CYCLES 16'd1600

`endif

/* File: src/lcsr_pkg.sv */
/*
  Types for the controller status/control bank.
  Assumes the map header supplies all numbers.
*/
package lcsr_pkg;
  typedef enum logic [1:0] {
    LCSR_IDLE,
    LCSR_FETCH,
    LCSR_RUN
  } lcsr_state_t;
endpackage

/* File: src/lcsr_poll_timer.sv */
/*
  Periodic transmit poll timer with immediate demand.
  Assumes one clock; demand is a level held until the poll pulse.
*/
`timescale 1ns/1ps
`include "lcsr_map.svh"
module lcsr_poll_timer #(
  parameter logic [15:0] POLL_CYCLES = `LCSR_POLL_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire logic i_demand,
  // Result
  output logic o_poll
);
  typedef struct packed {
    logic [15:0] cnt;
    logic poll;
  } lcsr_pt_t;
  lcsr_pt_t st_reg;
  lcsr_pt_t st_next;

  // Count down; demand fires the ring check at once
  always_comb begin
    st_next = st_reg;
    st_next.poll = 1'b0;
    if (!i_run) begin
      st_next.cnt = POLL_CYCLES;
    end else if ((i_demand && !st_reg.poll) || st_reg.cnt == 16'h0000) begin
      st_next.poll = 1'b1;
      st_next.cnt = POLL_CYCLES;
    end else begin
      st_next.cnt = st_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_poll = st_reg.poll;
endmodule

/* File: src/lcsr_mem_watch.sv */
/*
  Bus master ready watchdog: raises a one-cycle timeout pulse when ready
  does not follow the address strobe within the timeout count.
  Assumes strobe and ready synchronous to the core clock.
*/
`timescale 1ns/1ps
`include "lcsr_map.svh"
module lcsr_mem_watch #(
  parameter int TIMEOUT = `LCSR_MEM_TIMEOUT
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Master cycle
  input wire logic i_strobe,
  input wire logic i_ready,
  // Result
  output logic o_timeout
);
  typedef struct packed {
    logic busy;
    logic [9:0] cnt;
    logic tmo;
  } lcsr_mw_t;
  lcsr_mw_t st_reg;
  lcsr_mw_t st_next;

  // Count from strobe until ready or timeout
  always_comb begin
    st_next = st_reg;
    st_next.tmo = 1'b0;
    if (st_reg.busy) begin
      if (i_ready) begin
        st_next.busy = 1'b0;
      end else if (st_reg.cnt == 10'(TIMEOUT - 1)) begin
        st_next.busy = 1'b0;
        st_next.tmo = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 10'h001;
      end
    end else if (i_strobe) begin
      st_next.busy = 1'b1;
      st_next.cnt = 10'h000;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_timeout = st_reg.tmo;
endmodule

/* File: src/lcsr_ctrl.sv */
/*
  Controller status/control register bank on an AXI4-Lite slave:
  command bits, run status, interrupt summary and pin, event flags.
  Assumes engine events are one-cycle pulses synchronous to i_core_clk.
*/
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "lcsr_map.svh"
// Overview of operation
// - Summary set by any unmasked source flag except collision
// - Pin high while pin enable clear
// - Summary read-only, clears with sources/stop
// - Pin enable read/write, cleared by stop
// - Begin sets receiver running unless receive-disabled
// - Receiver running cleared by setup/timeout/stop
// - Begin sets transmitter running unless transmit-disabled
// - Poll demand checks transmit ring immediately
// - Poll demand write-one, self clearing
// - Stop halts activity until begin/initialize
// - Stop wins when all three written
// - Stop set by reset, write one
// - Begin enables operation and clears stop
// - Initialization completes before begin operation
// - Begin write-one, cleared by stop
// - Initialize starts block fetch, clears stop
// - Initialize not cleared on completion
// - Setup complete set after block stored
// - Memory timeout after 512 unanswered counts
module lcsr_ctrl
  import lcsr_pkg::*;
#(
  parameter int INIT_WORDS = `LCSR_INIT_WORDS,
  parameter int MEM_TIMEOUT = `LCSR_MEM_TIMEOUT
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Engine events, one-cycle pulses
  input wire logic i_overlength,
  input wire logic i_collision_err,
  input wire logic i_missed_frame,
  input wire logic i_rx_done,
  input wire logic i_tx_done,
  input wire logic i_loopback_err,
  input wire logic i_tx_begin,
  input wire logic i_tx_underrun,
  // Init block fetch interface
  input wire logic i_init_word_ok,
  // Bus master watch
  input wire logic i_data_address_strobe,
  input wire logic i_mem_ready,
  // Status to engines
  output logic o_receiver_running,
  output logic o_transmitter_running,
  output logic o_init_fetch,
  output logic o_tx_poll,
  output logic o_stopped,
  // Interrupt pin
  output logic o_interrupt_n
);
  typedef struct packed {
    lcsr_state_t state;
    logic [7:0] fetch_cnt;
    logic start_pend;
    logic stop;
    logic begin_op;
    logic init;
    logic poll_now;
    logic ien;
    logic receiver_running;
    logic transmitter_running;
    logic [15:8] flags;
    logic [1:0] xflags;
    logic [15:0] mask;
    logic [1:0] xmask;
    logic [1:0] cfg;
    logic aw_ok;
    logic w_ok;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq_n;
    logic poll_out;
  } lcsr_st_t;

  lcsr_st_t st_reg;
  lcsr_st_t st_next;
  logic poll_pulse;
  logic mem_tmo;

  // Whether an offset maps to a register
  function automatic logic lcsr_hit(input logic [11:0] a);
    lcsr_hit = (a == `LCSR_OFS_CSC) || (a == `LCSR_OFS_MASK) ||
               (a == `LCSR_OFS_XMASK) || (a == `LCSR_OFS_CFG) ||
               (a == `LCSR_OFS_EVT);
  endfunction

  // Pin sources: unmasked flags except receive done and collision
  function automatic logic lcsr_pin_src(input lcsr_st_t s);
    logic [15:8] m;
    m = s.flags & ~s.mask[15:8];
    lcsr_pin_src = m[`LCSR_B_OVL] | m[`LCSR_B_MISS] | m[`LCSR_B_MEM] |
                   m[`LCSR_B_TXD] | m[`LCSR_B_SET] |
                   |(s.xflags & ~s.xmask);
  endfunction

  // Summary includes unmasked receive done as well
  function automatic logic lcsr_summary(input lcsr_st_t s);
    lcsr_summary = lcsr_pin_src(s) |
                   (s.flags[`LCSR_B_RXD] & ~s.mask[`LCSR_B_RXD]);
  endfunction

  // Full control/status word as read back
  function automatic logic [15:0] lcsr_csc(input lcsr_st_t s);
    logic [15:0] v;
    v = '0;
    v[15:8] = s.flags;
    v[`LCSR_B_ERR] = s.flags[`LCSR_B_OVL] | s.flags[`LCSR_B_COL] |
                     s.flags[`LCSR_B_MISS] | s.flags[`LCSR_B_MEM];
    v[`LCSR_B_INT] = lcsr_summary(s);
    v[`LCSR_B_IEN] = s.ien;
    v[`LCSR_B_RECEIVER_RUNNING] = s.receiver_running;
    v[`LCSR_B_TRANSMITTER_RUNNING] = s.transmitter_running;
    v[`LCSR_B_POLL] = s.poll_now;
    v[`LCSR_B_STOP] = s.stop;
    v[`LCSR_B_BEGIN] = s.begin_op;
    v[`LCSR_B_INIT] = s.init;
    lcsr_csc = v;
  endfunction

  lcsr_poll_timer u_poll (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(st_reg.transmitter_running),
    .i_demand(st_reg.poll_now),
    .o_poll(poll_pulse)
  );

  lcsr_mem_watch #(
    .TIMEOUT(MEM_TIMEOUT)
  ) u_watch (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_strobe(i_data_address_strobe),
    .i_ready(i_mem_ready),
    .o_timeout(mem_tmo)
  );

  // Bus handshake, command decode, flags and run state
  always_comb begin
    logic do_wr;
    logic lo;
    logic [15:0] wd;
    logic wr_stop;
    logic wr_begin;
    logic wr_init;
    logic setup_done;
    logic [15:8] w1c;
    logic [1:0] xw1c;
    logic [15:8] ev;
    logic [1:0] xev;
    do_wr = 1'b0;
    lo = 1'b0;
    wd = '0;
    wr_stop = 1'b0;
    wr_begin = 1'b0;
    wr_init = 1'b0;
    setup_done = 1'b0;
    w1c = '0;
    xw1c = '0;
    ev = '0;
    xev = '0;
    st_next = st_reg;
    // No ring check reaches the engine while stopped
    st_next.poll_out = poll_pulse && !st_reg.stop;

    // Capture address and data in either order
    if (i_awvalid && !st_reg.aw_ok) begin
      st_next.aw_ok = 1'b1;
      st_next.awaddr = i_awaddr;
    end
    if (i_wvalid && !st_reg.w_ok) begin
      st_next.w_ok = 1'b1;
      st_next.wdata = i_wdata;
      lo = i_wstrb[0] & i_wstrb[1];
    end else begin
      lo = 1'b1;
    end
    if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid) begin
      do_wr = 1'b1;
      wd = st_reg.wdata[15:0];
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = lcsr_hit(st_reg.awaddr) ? 2'b00 : 2'b10;
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Register writes
    // single-write command decode
    if (do_wr && st_reg.awaddr == `LCSR_OFS_CSC) begin
      wr_stop = wd[`LCSR_B_STOP];
      wr_begin = wd[`LCSR_B_BEGIN];
      wr_init = wd[`LCSR_B_INIT];
      w1c = wd[15:8];
      st_next.ien = wd[`LCSR_B_IEN];
      if (wd[`LCSR_B_POLL]) begin
        st_next.poll_now = 1'b1;
      end
    end
    if (do_wr && st_reg.awaddr == `LCSR_OFS_MASK) begin
      st_next.mask = wd;
    end
    if (do_wr && st_reg.awaddr == `LCSR_OFS_XMASK) begin
      st_next.xmask = wd[1:0];
      xw1c = wd[9:8];
    end
    if (do_wr && st_reg.awaddr == `LCSR_OFS_CFG && st_reg.stop) begin
      st_next.cfg = wd[1:0];
    end

    if (poll_pulse) begin
      st_next.poll_now = 1'b0;
    end

    unique case (st_reg.state)
      LCSR_IDLE: begin
      end
      LCSR_FETCH: begin
        if (i_init_word_ok) begin
          if (st_reg.fetch_cnt == 8'(INIT_WORDS - 1)) begin
            setup_done = 1'b1;
            st_next.state = LCSR_RUN;
          end else begin
            st_next.fetch_cnt = st_reg.fetch_cnt + 8'h01;
          end
        end
      end
      LCSR_RUN: begin
      end
    endcase

    // Event flags: set wins over write-one clear
    ev[`LCSR_B_OVL] = i_overlength;
    ev[`LCSR_B_COL] = i_collision_err;
    ev[`LCSR_B_MISS] = i_missed_frame;
    ev[`LCSR_B_MEM] = mem_tmo;
    ev[`LCSR_B_RXD] = i_rx_done;
    ev[`LCSR_B_TXD] = i_tx_done;
    ev[`LCSR_B_SET] = setup_done;
    xev[`LCSR_X_LBE] = i_loopback_err;
    xev[`LCSR_X_TXB] = i_tx_begin;
    st_next.flags = (st_reg.flags & ~w1c) | ev;
    st_next.xflags = (st_reg.xflags & ~xw1c) | xev;

    if (setup_done && st_reg.start_pend) begin
      st_next.start_pend = 1'b0;
      st_next.begin_op = 1'b1;
    end

    if ((wr_begin && !wr_init && st_reg.init && st_reg.state == LCSR_RUN) ||
        (setup_done && st_reg.start_pend)) begin
      st_next.receiver_running = !st_reg.cfg[`LCSR_C_DRX];
      st_next.transmitter_running = !st_reg.cfg[`LCSR_C_DTX];
    end
    if ((setup_done && st_reg.cfg[`LCSR_C_DRX]) || mem_tmo) begin
      st_next.receiver_running = 1'b0;
    end
    if ((setup_done && st_reg.cfg[`LCSR_C_DTX]) || mem_tmo || i_tx_underrun) begin
      st_next.transmitter_running = 1'b0;
    end

    if (wr_init) begin
      st_next.init = 1'b1;
      st_next.stop = 1'b0;
      st_next.state = LCSR_FETCH;
      st_next.fetch_cnt = 8'h00;
      st_next.start_pend = wr_begin;
    end else if (wr_begin) begin
      st_next.begin_op = 1'b1;
      st_next.stop = 1'b0;
    end

    if (wr_stop) begin
      st_next.stop = 1'b1;
      st_next.begin_op = 1'b0;
      st_next.init = 1'b0;
      st_next.start_pend = 1'b0;
      st_next.poll_now = 1'b0;
      st_next.poll_out = 1'b0;
      st_next.ien = 1'b0;
      st_next.receiver_running = 1'b0;
      st_next.transmitter_running = 1'b0;
      st_next.flags = '0;
      st_next.xflags = '0;
      st_next.state = LCSR_IDLE;
    end

    // Read channel
    if (i_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = lcsr_hit(i_araddr) ? 2'b00 : 2'b10;
      st_next.rdata = '0;
      if (i_araddr == `LCSR_OFS_CSC) begin
        st_next.rdata[15:0] = lcsr_csc(st_reg);
      end else if (i_araddr == `LCSR_OFS_MASK) begin
        st_next.rdata[15:0] = st_reg.mask;
      end else if (i_araddr == `LCSR_OFS_XMASK) begin
        st_next.rdata[9:8] = st_reg.xflags;
        st_next.rdata[1:0] = st_reg.xmask;
      end else if (i_araddr == `LCSR_OFS_CFG) begin
        st_next.rdata[1:0] = st_reg.cfg;
      end else if (i_araddr == `LCSR_OFS_EVT) begin
        st_next.rdata[1:0] = {st_reg.state == LCSR_FETCH, st_reg.start_pend};
      end
    end else if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end

    st_next.irq_n = !(st_next.ien && lcsr_pin_src(st_next));
    if (!lcsr_summary(st_next)) begin
      st_next.irq_n = 1'b1;
    end
    if (!lo) begin
      st_next.irq_n = st_next.irq_n;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.state <= LCSR_IDLE;
      st_reg.stop <= 1'b1;
      st_reg.irq_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign o_awready = !st_reg.aw_ok;
  assign o_wready = !st_reg.w_ok;
  assign o_bvalid = st_reg.bvalid;
  assign o_bresp = st_reg.bresp;
  assign o_arready = !st_reg.rvalid;
  assign o_rvalid = st_reg.rvalid;
  assign o_rdata = st_reg.rdata;
  assign o_rresp = st_reg.rresp;
  assign o_receiver_running = st_reg.receiver_running;
  assign o_transmitter_running = st_reg.transmitter_running;
  assign o_init_fetch = (st_reg.state == LCSR_FETCH);
  assign o_tx_poll = st_reg.poll_out;
  assign o_stopped = st_reg.stop;
  assign o_interrupt_n = st_reg.irq_n;
endmodule

/* File: verification/lcsr_ctrl_props.sv */
/*
  Port-level assertions for the status/control bank.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module lcsr_ctrl_props #(
  parameter int MEM_TIMEOUT = 512
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Bus and engine inputs
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic i_tx_underrun,
  input wire logic i_data_address_strobe,
  input wire logic i_mem_ready,
  // Outputs watched
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic o_receiver_running,
  input wire logic o_transmitter_running,
  input wire logic o_init_fetch,
  input wire logic o_tx_poll,
  input wire logic o_stopped,
  input wire logic o_interrupt_n
);
  logic waiting;
  int unsigned wait_cnt;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Cycles since an unanswered strobe, saturating
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      waiting <= 1'b0;
      wait_cnt <= 0;
    end else if (i_mem_ready) begin
      waiting <= 1'b0;
      wait_cnt <= 0;
    end else if (i_data_address_strobe) begin
      waiting <= 1'b1;
      wait_cnt <= 0;
    end else if (waiting && wait_cnt < MEM_TIMEOUT + 4) begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  a_stopped_no_run: assert property (
    o_stopped |-> !o_receiver_running && !o_transmitter_running && !o_init_fetch)
    else $error("running or fetching while stopped");
  a_stop_quiet_pin: assert property (
    o_stopped && $past(o_stopped) |-> o_interrupt_n)
    else $error("interrupt pin low while stopped");
  a_rx_after_init: assert property (
    $rose(o_receiver_running) |-> !o_stopped && !o_init_fetch)
    else $error("receiver started before setup finished");
  a_poll_one_cycle: assert property (
    o_tx_poll |=> !o_tx_poll)
    else $error("poll pulse longer than one cycle");
  a_stop_no_poll: assert property (
    o_stopped |-> !o_tx_poll)
    else $error("poll while stopped");
  a_underrun_tx_off: assert property (
    i_tx_underrun |-> ##[1:2] !o_transmitter_running)
    else $error("transmitter still on after underrun");
  a_timeout_run_off: assert property (
    waiting && wait_cnt == MEM_TIMEOUT + 3 |-> !o_receiver_running && !o_transmitter_running)
    else $error("running after memory timeout");
  a_bresp_holds: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
endmodule

bind lcsr_ctrl lcsr_ctrl_props #(.MEM_TIMEOUT(MEM_TIMEOUT)) i_lcsr_ctrl_props (
  .i_core_clk, .i_rst, .i_bready, .i_rready, .i_tx_underrun, .i_data_address_strobe,
  .i_mem_ready, .o_bvalid, .o_bresp, .o_rvalid, .o_rdata, .o_receiver_running,
  .o_transmitter_running, .o_init_fetch, .o_tx_poll, .o_stopped, .o_interrupt_n
);

/* File: verification/lcsr_engine_model.sv */
/*
  Engine-side model: init block word fetch and memory ready answers.
  Assumes the bench pulses i_mem_go for one cycle.
*/
`timescale 1ns/1ps
module lcsr_engine_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Controls
  input wire logic i_fetch,
  input wire logic i_slow,
  input wire logic i_mem_go,
  input wire logic i_hang,
  // To the bank
  output logic o_word_ok,
  output logic o_strobe,
  output logic o_ready
);
  logic [1:0] div;
  logic [1:0] lat;

  // Word pulses every other or every fourth cycle; ready 4 cycles after strobe
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      {div, lat, o_word_ok, o_strobe, o_ready} <= '0;
    end else begin
      div <= div + 2'd1;
      o_word_ok <= i_fetch && !o_word_ok && (!i_slow || div == 2'd3);
      o_strobe <= i_mem_go;
      lat <= o_strobe ? 2'd3 : (lat != 2'd0 ? lat - 2'd1 : 2'd0);
      o_ready <= !i_hang && lat == 2'd1;
    end
  end
endmodule

/* File: verification/lan_controller_csr_control_tb.sv */
/*
  Self-checking bench for the status/control bank over AXI4-Lite.
  Assumes the engine model answers fetches and memory cycles.
*/
`timescale 1ns/1ps
`include "lcsr_map.svh"
module lan_controller_csr_control_tb;
  localparam int MT = 8;
  localparam logic [15:0] CLR [7] = '{16'h4040, 16'h2040, 16'h1040, 16'h0440,
    16'h0240, 16'h0200, 16'h0100};
  localparam logic [6:0] PIN_HI = 7'b0001010;
  logic i_core_clk, i_rst = 1'b1;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [11:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, o_rdata, rd;
  logic [3:0] i_wstrb = 4'hf;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_init_fetch, o_tx_poll;
  logic i_overlength = 0, i_collision_err = 0, i_missed_frame = 0, i_rx_done = 0;
  logic i_tx_done = 0, i_loopback_err = 0, i_tx_begin = 0, i_tx_underrun = 0;
  logic i_init_word_ok, i_data_address_strobe, i_mem_ready, o_stopped, o_interrupt_n;
  logic o_receiver_running, o_transmitter_running, slow = 1, mem_go = 0, hang = 0;
  int fails = 0, tests_run = 0, polls = 0, p0, i;

  lcsr_ctrl #(.INIT_WORDS(2), .MEM_TIMEOUT(MT)) i_lcsr_ctrl (
    .i_core_clk, .i_rst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
    .i_rready, .o_rdata, .o_rresp, .i_overlength, .i_collision_err, .i_missed_frame,
    .i_rx_done, .i_tx_done, .i_loopback_err, .i_tx_begin, .i_tx_underrun, .i_init_word_ok,
    .i_data_address_strobe, .i_mem_ready, .o_receiver_running, .o_transmitter_running,
    .o_init_fetch, .o_tx_poll, .o_stopped, .o_interrupt_n);
  lcsr_engine_model i_lcsr_engine_model (.i_core_clk, .i_rst, .i_fetch(o_init_fetch),
    .i_slow(slow), .i_mem_go(mem_go), .i_hang(hang), .o_word_ok(i_init_word_ok),
    .o_strobe(i_data_address_strobe), .o_ready(i_mem_ready));

  // Clock and poll pulse counter
  initial begin
    i_core_clk = 0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) if (o_tx_poll === 1'b1) polls++;

  task summarize;
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task wr(input logic [11:0] a, input logic [15:0] d);
    logic ta, tw, tk, done;
    done = 0;
    @(posedge i_core_clk);
    i_awvalid <= 1; i_awaddr <= a; i_wvalid <= 1; i_wdata <= {16'h0000, d}; i_bready <= 1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge i_core_clk);
      ta = i_awvalid && o_awready; tw = i_wvalid && o_wready; tk = o_bvalid && i_bready;
      if (tk) rsp = o_bresp;
      @(posedge i_core_clk);
      if (ta) i_awvalid <= 0;
      if (tw) i_wvalid <= 0;
      if (tk) begin
        i_bready <= 0;
        done = 1;
      end
    end
    if (!done) begin
      fails++;
      summarize();
    end
  endtask
  task rdr(input logic [11:0] a);
    logic ta, done;
    done = 0;
    @(posedge i_core_clk);
    i_arvalid <= 1; i_araddr <= a; i_rready <= 1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge i_core_clk);
      ta = i_arvalid && o_arready; done = o_rvalid && i_rready; rd = o_rdata; rsp = o_rresp;
      @(posedge i_core_clk);
      if (ta) i_arvalid <= 0;
      if (done) i_rready <= 0;
    end
    if (!done) begin
      fails++;
      summarize();
    end
  endtask
  task ev_pulse(input logic [7:0] m);
    @(posedge i_core_clk);
    {i_tx_underrun, i_tx_begin, i_loopback_err, i_tx_done, i_rx_done, i_missed_frame,
      i_collision_err, i_overlength} <= m;
    @(posedge i_core_clk);
    {i_tx_underrun, i_tx_begin, i_loopback_err, i_tx_done, i_rx_done, i_missed_frame,
      i_collision_err, i_overlength} <= 8'h00;
    repeat (2) @(negedge i_core_clk);
  endtask
  // Wait out the init fetch, receiver must stay off meanwhile
  task fetch_wait;
    int n;
    @(negedge i_core_clk);
    for (n = 0; n < 80 && o_init_fetch !== 1'b0; n++) begin
      check("rx in fetch", 32'(o_receiver_running), 32'h0);
      @(negedge i_core_clk);
    end
    if (n == 80) begin
      fails++;
      summarize();
    end
    repeat (2) @(negedge i_core_clk);
  endtask
  task go_mem(input logic h);
    @(posedge i_core_clk);
    hang <= h; mem_go <= 1;
    @(posedge i_core_clk);
    mem_go <= 0;
    repeat (MT + 6) @(negedge i_core_clk);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst <= 0;
    rdr(`LCSR_OFS_CSC); check("csc reset", rd, 32'h0004);
    rdr(`LCSR_OFS_MASK); check("mask reset", rd, 32'h0);
    rdr(12'h020); check("unmapped resp", 32'(rsp), 32'h2);
    wr(12'h020, 16'h0000); check("unmapped bresp", 32'(rsp), 32'h2);
    wr(`LCSR_OFS_CSC, 16'h0080); check("bresp okay", 32'(rsp), 32'h0);
    rdr(`LCSR_OFS_CSC); check("csc ignore", rd, 32'h0004);
    wr(`LCSR_OFS_CFG, 16'h0000);
    wr(`LCSR_OFS_CSC, 16'h0043);
    fetch_wait();
    check("pin setup", 32'(o_interrupt_n), 32'h0);
    rdr(`LCSR_OFS_CSC); check("csc running", rd, 32'h01f3);
    wr(`LCSR_OFS_CSC, 16'h0140);
    repeat (2) @(negedge i_core_clk);
    check("pin cleared", 32'(o_interrupt_n), 32'h1);
    for (i = 0; i < 7; i++) begin
      ev_pulse(8'h01 << i);
      check("pin event", 32'(o_interrupt_n), 32'(PIN_HI[i]));
      wr(i < 5 ? `LCSR_OFS_CSC : `LCSR_OFS_XMASK, CLR[i]);
      repeat (2) @(negedge i_core_clk);
      check("pin after clear", 32'(o_interrupt_n), 32'h1);
    end
    wr(`LCSR_OFS_MASK, 16'h0200);
    ev_pulse(8'h10);
    rdr(`LCSR_OFS_CSC); check("masked summary", rd, 32'h0273);
    wr(`LCSR_OFS_CSC, 16'h0240);
    wr(`LCSR_OFS_MASK, 16'h0000);
    wr(`LCSR_OFS_CSC, 16'h0000);
    ev_pulse(8'h10);
    check("pin disabled", 32'(o_interrupt_n), 32'h1);
    rdr(`LCSR_OFS_CSC); check("enable cleared", rd, 32'h02b3);
    wr(`LCSR_OFS_CSC, 16'h0240);
    p0 = polls;
    wr(`LCSR_OFS_CSC, 16'h0048);
    repeat (4) @(negedge i_core_clk);
    check("poll demand", 32'(polls != p0), 32'h1);
    rdr(`LCSR_OFS_CSC); check("poll cleared", rd, 32'h0073);
    go_mem(1'b0);
    check("rx after ready", 32'(o_receiver_running), 32'h1);
    go_mem(1'b1);
    check("rx after timeout", 32'(o_receiver_running), 32'h0);
    rdr(`LCSR_OFS_CSC); check("timeout flag", rd, 32'h88c3);
    wr(`LCSR_OFS_CSC, 16'h0007);
    rdr(`LCSR_OFS_CSC); check("stop wins", rd, 32'h0004);
    wr(`LCSR_OFS_CFG, 16'h0001);
    rdr(`LCSR_OFS_CFG); check("cfg readback", rd, 32'h1);
    wr(`LCSR_OFS_CSC, 16'h0003);
    fetch_wait();
    check("rx disabled", 32'(o_receiver_running), 32'h0);
    check("tx enabled", 32'(o_transmitter_running), 32'h1);
    rdr(`LCSR_OFS_EVT); check("no begin pending", rd, 32'h0);
    ev_pulse(8'h80);
    check("tx underrun", 32'(o_transmitter_running), 32'h0);
    wr(`LCSR_OFS_CSC, 16'h0004);
    wr(`LCSR_OFS_CSC, 16'h0002);
    check("begin clears stop", 32'(o_stopped), 32'h0);
    summarize();
  end
endmodule
